/* pkg/sciad_params.svh */
/*
  constants for the serial adapter: widths, counts, reset values.
  assumes inclusion by bare name from the adapter package and modules.
*/
`ifndef SCIAD_PARAMS_SVH
`define SCIAD_PARAMS_SVH

// parallel byte width on both paths
`define SCIAD_DATA_W      8
// shift rises after the start bit: 8 data bits then the stop bit
`define SCIAD_TX_LAST     4'h8
// tx shift counter reset value
`define SCIAD_CNT_RST     4'h0
// line level for mark (idle) and for the start bit
`define SCIAD_MARK        1'b1
`define SCIAD_SPACE       1'b0
// reset value of the deserialising shift register
`define SCIAD_SHREG_CLR   8'h00
// fill value shifted into the serialiser as it empties
`define SCIAD_FILL_ONES   1'b1
// synchroniser idle levels: strobe low, bit clock high, serial high
`define SCIAD_PIN_IDLE    3'h3
// entries of the receive buffer
`define SCIAD_BUF_DEPTH   2
// bound, in sys_clk cycles, for one bit time in checks (bench: 16)
`define SCIAD_BIT_MAX     64

`endif

/* pkg/sciad_pkg.sv */
/*
  types shared by the serial adapter modules.
  assumes sciad_params.svh sits on the include path.
*/
`include "sciad_params.svh"

package sciad_pkg;

  // pins that arrive from outside the sys_clk domain
  typedef struct packed {
    logic kb_strobe;   // keyboard strobe, rising edge starts a byte
    logic bit_clock;   // bit-rate clock from the controller
    logic serial;      // controller serial output, NRZ
  } sciad_pins_t;

  // serialiser sequence
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_SHIFT
  } sciad_tx_state_t;

  // shift register holds inverted bits, last received in bit 0
  function automatic logic [`SCIAD_DATA_W-1:0] sciad_unpack(
    input logic [`SCIAD_DATA_W-1:0] shreg
  );
    logic [`SCIAD_DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < `SCIAD_DATA_W; i++) begin
      r[i] = ~shreg[`SCIAD_DATA_W-1-i];
    end
    return r;
  endfunction : sciad_unpack

endpackage : sciad_pkg

/* verilog/sciad_sync2.sv */
/*
  two flip-flop synchroniser for a vector of unrelated levels.
  assumes each bit is a slow level, not a multi-bit word.
*/
`timescale 1ns/100ps

module sciad_sync2 #(
  parameter int               W    = 1,
  parameter logic [W-1:0]     INIT = '0
) (
  // clock and reset
  input  wire logic           sys_clk,
  input  wire logic           rst_n,
  // levels
  input  wire logic [W-1:0]   d,
  output logic      [W-1:0]   q
);

  logic [W-1:0] meta;  // first stage, read only by q

  ////////////////////////////////////////////////////////////////////
  // two stages, reset to the idle level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= INIT;
      q    <= INIT;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : sciad_sync2

/* verilog/sciad_fifo2.sv */
/*
  small valid/ready buffer, two entries by default.
  assumes DEPTH is a power of two and both sides share sys_clk.
*/
`timescale 1ns/100ps

module sciad_fifo2 #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem [DEPTH];  // storage
  logic [PW-1:0] wr_ptr;       // next write slot
  logic [PW-1:0] rd_ptr;       // oldest entry
  logic [PW:0]   count;        // entries held
  logic          push;
  logic          pop;

  // full and empty come straight from the count
  assign in_ready  = (count < (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  ////////////////////////////////////////////////////////////////////
  // storage, written only on an accepted push
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pointers and count
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule : sciad_fifo2

/* verilog/sciad_adapter.sv */
/*
  glue between byte-wide parallel devices and a controller serial port
  running NRZ with its bit-rate clock driven out. a keyboard path turns
  strobed bytes into start/data/stop frames; a display path turns the
  controller's serial output back into bytes with a data-ready strobe.
  assumes the controller supplies the bit clock (rising edge mid-bit)
  and that all pins are asynchronous to sys_clk.
*/
`timescale 1ns/100ps

module sciad_adapter
  import sciad_pkg::*;
(
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     reset_n,
  // controller serial pins
  input  wire logic                     bit_clock_pin,
  input  wire logic                     serial_tx_pin,
  output logic                          adapter_tx_out,
  // keyboard side
  input  wire logic [`SCIAD_DATA_W-1:0] kb_byte,
  input  wire logic                     kb_strobe,
  output logic                          kb_busy,
  // display side, octal latch and strobe
  output logic      [`SCIAD_DATA_W-1:0] disp_byte,
  output logic                          disp_ready_n,
  // display side, buffered stream
  output logic                          rx_valid,
  input  wire logic                     rx_ready,
  output logic      [`SCIAD_DATA_W-1:0] rx_data,
  output logic                          rx_room
);

  ////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta;   // first release stage
  logic rst_n;      // released copy used everywhere

  // assert at once, release after two edges
  // a synchronous release keeps every flop leaving reset on one edge
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////
  // pin synchronisation and bit clock edges
  sciad_pins_t pins_raw;    // pins as they arrive
  sciad_pins_t pins_s;      // after two flip-flops
  logic        bclk_prev;   // bit clock one cycle ago
  logic        strobe_prev; // keyboard strobe one cycle ago
  logic        bit_rise;    // mid-bit enable
  logic        bit_fall;    // bit boundary enable
  logic        strobe_rise; // keyboard strobe edge

  assign pins_raw = '{kb_strobe: kb_strobe, bit_clock: bit_clock_pin,
                      serial: serial_tx_pin};

  // pulled-up lines idle high, keyboard strobe idles low
  // matching the pins' idle levels avoids a false edge after reset
  sciad_sync2 #(
    .W    ($bits(sciad_pins_t)),
    .INIT (`SCIAD_PIN_IDLE)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d       (pins_raw),
    .q       (pins_s)
  );

  // edges are seen on the synchronised copy only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bclk_prev   <= 1'b1;
      strobe_prev <= 1'b0;
    end else begin
      bclk_prev   <= pins_s.bit_clock;
      strobe_prev <= pins_s.kb_strobe;
    end
  end

  assign bit_rise    = pins_s.bit_clock && !bclk_prev;
  assign bit_fall    = !pins_s.bit_clock && bclk_prev;
  assign strobe_rise = pins_s.kb_strobe && !strobe_prev;

  ////////////////////////////////////////////////////////////////////
  // keyboard path: capture, bit-clock sync, serialise
  sciad_tx_state_t                tx_state;  // serialiser state
  logic [`SCIAD_DATA_W-1:0]       kb_hold;   // byte caught at strobe
  logic                           kb_armed;  // byte waiting to go
  logic                           tx_sync1;  // first bit-clock stage
  logic                           tx_sync2;  // second bit-clock stage
  logic [`SCIAD_DATA_W-1:0]       tx_shreg;  // outgoing shift register
  logic [3:0]                     tx_cnt;    // shift rises so far

  // busy from strobe until the stop bit is on the line; the source
  // paces itself on it, one byte per frame at most
  assign kb_busy = kb_armed || (tx_state != TX_IDLE);

  // strobe capture; edges while busy are dropped
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      kb_hold  <= '0;
      kb_armed <= 1'b0;
    end else if (strobe_rise && !kb_busy) begin
      kb_hold  <= kb_byte;
      kb_armed <= 1'b1;
    end else if (bit_rise && tx_sync2 && tx_state == TX_IDLE) begin
      kb_armed <= 1'b0;
    end
  end

  // request passes two bit-clock stages before the frame starts
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sync1 <= 1'b0;
      tx_sync2 <= 1'b0;
    end else if (bit_rise) begin
      tx_sync1 <= kb_armed && !tx_sync2;
      tx_sync2 <= tx_sync1 && !tx_sync2;
    end
  end

  // frame generator: start, eight data lsb first, stop by fill
  // the start waits for a mid-bit rise, so up to three bit times
  // pass between strobe and start bit; that latency buys a clean sync
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state       <= TX_IDLE;
      tx_shreg       <= '1;
      tx_cnt         <= `SCIAD_CNT_RST;
      adapter_tx_out <= `SCIAD_MARK;
    end else if (bit_rise) begin
      case (tx_state)
        TX_IDLE: begin
          if (tx_sync2) begin
            adapter_tx_out <= `SCIAD_SPACE;
            tx_shreg       <= kb_hold;
            tx_cnt         <= `SCIAD_CNT_RST;
            tx_state       <= TX_SHIFT;
          end else begin
            adapter_tx_out <= `SCIAD_MARK;
          end
        end
        TX_SHIFT: begin
          // each mid-bit rise moves one bit out, ones follow behind
          adapter_tx_out <= tx_shreg[0];
          tx_shreg <= {`SCIAD_FILL_ONES, tx_shreg[`SCIAD_DATA_W-1:1]};
          tx_cnt   <= tx_cnt + 4'h1;
          // ninth rise puts the stop bit out; line stays mark after
          if (tx_cnt == `SCIAD_TX_LAST) begin
            tx_state <= TX_IDLE;
          end
        end
        default: begin
          tx_state       <= TX_IDLE;
          adapter_tx_out <= `SCIAD_MARK;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // display path: inverted shift-in, start flag, latch, strobe
  logic [`SCIAD_DATA_W-1:0] rx_shreg;    // inverted incoming bits
  logic                     start_flag;  // start bit reached the end
  logic                     rx_push;     // byte latched this cycle

  // shift on mid-bit; the low strobe acts as the clear input
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_shreg     <= `SCIAD_SHREG_CLR;
      start_flag   <= 1'b0;
      disp_ready_n <= 1'b1;
    end else if (bit_rise) begin
      // inversion lets a clear-only register restart each byte
      rx_shreg <= {rx_shreg[`SCIAD_DATA_W-2:0],
                   !pins_s.serial};
      start_flag   <= rx_shreg[`SCIAD_DATA_W-1];
      disp_ready_n <= !start_flag;
    end else if (!disp_ready_n) begin
      rx_shreg   <= `SCIAD_SHREG_CLR;
      start_flag <= 1'b0;
    end
  end

  // octal latch on the falling edge after the flag is set
  assign rx_push = bit_fall && start_flag && disp_ready_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      disp_byte <= '0;
    end else if (rx_push) begin
      // held until the next byte, about ten bit times
      disp_byte <= sciad_unpack(rx_shreg);
    end
  end

  // buffered copy; rx_room low means a byte would be lost
  // two entries ride out a short stall; a longer one drops bytes
  sciad_fifo2 #(
    .W     (`SCIAD_DATA_W),
    .DEPTH (`SCIAD_BUF_DEPTH)
  ) u_rx_buf (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (rx_push),
    .in_ready  (rx_room),
    .in_data   (sciad_unpack(rx_shreg)),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  ////////////////////////////////////////////////////////////////////
  // checks
  // all checks stand down while the released reset copy is low
  AST_IDLE_MARK: assert property (
    tx_state == TX_IDLE && !tx_sync2 |=> adapter_tx_out == `SCIAD_MARK)
    else $error("line not at mark while idle");

  AST_START_BIT: assert property (
    bit_rise && tx_state == TX_IDLE && tx_sync2
    |=> adapter_tx_out == `SCIAD_SPACE && tx_state == TX_SHIFT)
    else $error("start bit missing");

  AST_STOP_BIT: assert property (
    bit_rise && tx_state == TX_SHIFT && tx_cnt == `SCIAD_TX_LAST
    |=> adapter_tx_out == `SCIAD_MARK && tx_state == TX_IDLE)
    else $error("stop bit not at mark");

  AST_SHIFT_ON_RISE: assert property (
    !bit_rise |=> $stable(adapter_tx_out))
    else $error("serial output moved off a mid-bit edge");

  AST_BUSY_IGNORE: assert property (
    kb_busy |=> $stable(kb_hold))
    else $error("held byte changed while busy");

  AST_INVERT_IN: assert property (
    bit_rise && disp_ready_n |=> rx_shreg[0] == !$past(pins_s.serial))
    else $error("serial bit not inverted into register");

  AST_FLAG_TO_STROBE: assert property (
    bit_rise && rx_shreg[`SCIAD_DATA_W-1] && disp_ready_n
    |=> start_flag ##[1:`SCIAD_BIT_MAX] !disp_ready_n)
    else $error("start flag did not lead to strobe");

  AST_LATCH: assert property (
    rx_push |=> disp_byte == sciad_unpack($past(rx_shreg)))
    else $error("latch missed the shift register");

  AST_STROBE_CLEARS: assert property (
    !disp_ready_n && !bit_rise |=> rx_shreg == `SCIAD_SHREG_CLR)
    else $error("strobe did not clear register");

  AST_STROBE_WIDTH: assert property (
    $fell(disp_ready_n) |-> ##[1:`SCIAD_BIT_MAX] $rose(disp_ready_n))
    else $error("strobe wider than bound");

  // frame start loads the byte held since the strobe
  AST_LOAD_ON_START: assert property (
    bit_rise && tx_state == TX_IDLE && tx_sync2
    |=> tx_shreg == $past(kb_hold))
    else $error("byte not loaded at start bit");

  // busy drops with the stop bit so the next strobe is taken
  AST_BUSY_CLEAR: assert property (
    bit_rise && tx_state == TX_SHIFT && tx_cnt == `SCIAD_TX_LAST
    |=> !kb_busy)
    else $error("busy still high after stop bit");

  // strobe returns high at the very next mid-bit
  AST_STROBE_ONE_BIT: assert property (
    bit_rise && !disp_ready_n |=> disp_ready_n)
    else $error("strobe low for more than one bit");

endmodule : sciad_adapter

/* dv/sciad_ctl_model.sv */
/*
  controller model: free-running bit clock, nrz frames out, frames in.
  assumes sys_clk stands for the controller's own input clock.
*/
`timescale 1ns/100ps

module sciad_ctl_model #(
  parameter int DIV = 16  // rate_select divide, 160 ns bit time
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // serial pins
  output logic      bit_clock_pin,
  output logic      serial_tx_pin,
  input  wire logic adapter_tx_out
);
  logic [7:0] tx_q[$];  // bytes waiting to go out
  logic [7:0] rx_q[$];  // bytes taken from good frames
  int         rx_errs;  // frames whose stop bit was low
  int         cnt;      // divider phase
  logic [8:0] tx_sh;    // data then stop, lsb first
  int         tx_left;  // bits still to send
  logic [7:0] rx_sh;    // data being collected
  int         rx_n;     // receive phase, 0 when idle

  // nrz mode: clock falls at bit start, rises mid-bit
  assign bit_clock_pin = (cnt >= DIV/2);

  ////////////////////////////////////////
  // sender and receiver; receiver samples well clear of the
  // adapter's edges, which lag our rises by a few cycles
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      tx_left <= 0;
      serial_tx_pin <= 1'b1;
      rx_n <= 0;
      rx_errs <= 0;
    end else begin
      cnt <= (cnt == DIV-1) ? 0 : cnt + 1;
      if (cnt == DIV-1) begin
        if (tx_left != 0) begin
          serial_tx_pin <= tx_sh[0];
          tx_sh <= tx_sh >> 1;
          tx_left <= tx_left - 1;
        end else if (tx_q.size() != 0) begin
          serial_tx_pin <= 1'b0;  // start bit
          tx_sh <= {1'b1, tx_q.pop_front()};
          tx_left <= 9;
        end
      end
      if (cnt == 3) begin
        if (rx_n == 0) begin
          if (adapter_tx_out === 1'b0)
            rx_n <= 1;
        end else if (rx_n < 9) begin
          rx_sh <= {adapter_tx_out, rx_sh[7:1]};
          rx_n <= rx_n + 1;
        end else begin
          if (adapter_tx_out === 1'b1)
            rx_q.push_back(rx_sh);
          else
            rx_errs <= rx_errs + 1;
          rx_n <= 0;
        end
      end
    end
  end

endmodule : sciad_ctl_model

/* dv/tb_sciad_adapter.sv */
/*
  bench for the serial adapter: byte pairs both ways from a table,
  then ignored strobes, buffer overflow and a reset in mid-frame.
  assumes the controller model makes the bit clock and serial data.
*/
`timescale 1ns/100ps

module tb_sciad_adapter
  import sciad_pkg::*;
;
  typedef struct packed {
    logic [7:0] kb;   // keyboard byte, expected in the frame
    logic [7:0] dsp;  // controller byte, expected latched
  } sciad_row_t;
  // ones after zeros shows the register was cleared
  sciad_row_t tab [4] = '{'{8'h00, 8'hFF}, '{8'hFF, 8'h00},
                          '{8'hA5, 8'h5A}, '{8'h01, 8'h80}};
  logic       sys_clk;
  logic       reset_n;
  logic       bclk;
  logic       ser;
  logic       tx_out;
  logic [7:0] kb_byte;
  logic       kb_strobe;
  logic       kb_busy;
  logic [7:0] disp_byte;
  logic       disp_ready_n;
  logic       rx_valid;
  logic       rx_ready;
  logic [7:0] rx_data;
  logic       rx_room;
  int         failures;
  int         cmp_count;
  int         lw;  // strobe low width in cycles

  sciad_adapter dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .bit_clock_pin(bclk), .serial_tx_pin(ser), .adapter_tx_out(tx_out),
    .kb_byte(kb_byte), .kb_strobe(kb_strobe), .kb_busy(kb_busy),
    .disp_byte(disp_byte), .disp_ready_n(disp_ready_n),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .rx_room(rx_room));
  sciad_ctl_model model (.sys_clk(sys_clk), .rst_n(reset_n),
    .bit_clock_pin(bclk), .serial_tx_pin(ser), .adapter_tx_out(tx_out));

  ////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask : check

  // 0 busy, 1 not busy, 2 strobe low, 3 strobe high, 4 frame seen
  function automatic logic hit(input int w);
    case (w)
      0: return kb_busy === 1'b1;
      1: return kb_busy === 1'b0;
      2: return disp_ready_n === 1'b0;
      3: return disp_ready_n === 1'b1;
      default: return model.rx_q.size() != 0;
    endcase
  endfunction : hit

  task automatic wait_for(input int w, input int lim);
    int n;
    n = 0;
    while (!hit(w) && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= lim) begin
      failures++;
      $display("mismatch at %0t: wait %0d ran out", $time, w);
      final_report();
    end
  endtask : wait_for

  // hold the strobe until the adapter takes the byte
  task automatic kb_send(input logic [7:0] b);
    @(posedge sys_clk);
    kb_byte <= b;
    kb_strobe <= 1'b1;
    wait_for(0, 10);
    @(posedge sys_clk);
    kb_strobe <= 1'b0;
  endtask : kb_send

  // one-cycle ready, then let the pop land
  task automatic pop_one;
    @(posedge sys_clk);
    rx_ready <= 1'b1;
    @(posedge sys_clk);
    rx_ready <= 1'b0;
    @(posedge sys_clk);
  endtask : pop_one

  ////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    failures++;
    $display("mismatch at %0t: run too long", $time);
    final_report();
  end

  initial begin
    reset_n = 1'b0;
    kb_byte = 8'h00;
    kb_strobe = 1'b0;
    rx_ready = 1'b0;
    failures = 0;
    cmp_count = 0;
    repeat (4) @(posedge sys_clk);
    check({tx_out, kb_busy, disp_ready_n, rx_valid, rx_room}, 8'h15,
          "reset levels");
    check(disp_byte, 8'h00, "reset latch");
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      model.tx_q.push_back(tab[i].dsp);
      kb_send(tab[i].kb);
      wait_for(2, 400);
      check(disp_byte, tab[i].dsp, "latch");
      check(rx_valid, 8'h01, "valid");
      check(rx_data, tab[i].dsp, "buffer");
      lw = 0;
      while (disp_ready_n === 1'b0 && lw < 64) begin
        @(posedge sys_clk);
        lw++;
      end
      check(8'(lw), 8'h10, "strobe width");
      pop_one();
      wait_for(4, 400);
      check(model.rx_q.pop_front(), tab[i].kb, "frame");
      wait_for(1, 40);
      check(tx_out, 8'h01, "idle line");
    end
    check(8'(model.rx_errs), 8'h00, "stop bits");
    // second strobe while the first byte still waits for its start bit must vanish
    kb_send(8'h5A);
    kb_send(8'hC3);
    wait_for(4, 400);
    check(model.rx_q.pop_front(), 8'h5A, "kept byte");
    repeat (224) @(posedge sys_clk);
    check(8'(model.rx_q.size()), 8'h00, "dropped byte");
    // three back-to-back bytes with the drain side stalled
    model.tx_q.push_back(8'h11);
    model.tx_q.push_back(8'h22);
    model.tx_q.push_back(8'h33);
    repeat (3) begin
      wait_for(2, 400);
      wait_for(3, 40);
    end
    check({rx_room, rx_valid}, 8'h01, "full");
    check(disp_byte, 8'h33, "latch after overrun");
    check(rx_data, 8'h11, "oldest");
    pop_one();
    check(rx_data, 8'h22, "second");
    pop_one();
    check({rx_room, rx_valid}, 8'h02, "empty");
    // reset in mid-frame on both paths
    model.tx_q.push_back(8'h96);
    kb_send(8'h81);
    repeat (100) @(posedge sys_clk);
    reset_n <= 1'b0;
    @(posedge sys_clk);
    @(posedge sys_clk);
    check({tx_out, kb_busy, disp_ready_n}, 8'h05, "reset mid");
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    model.tx_q.push_back(8'h69);
    wait_for(2, 400);
    check(disp_byte, 8'h69, "after reset");
    final_report();
  end

endmodule : tb_sciad_adapter
